// File: logic/lpf_filter.sv
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module lpf_filter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lpf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lpf_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [lpf_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pkt_valid,
  input wire lpf_pkg::lpf_hdr_t pkt_hdr,
  output logic filter_hit_event
);
  import lpf_pkg::*;

  // ************************************************
  // Register storage
  // ************************************************
  logic [DATA_W-1:0] match_low_reg;
  logic [DATA_W-1:0] packet_filter_mask_low_reg;
  logic [DATA_W-1:0] match_high_reg;
  logic [DATA_W-1:0] mask_high_reg;
  logic [DATA_W-1:0] hit_count_reg;
  logic hit_reg;

  // ************************************************
  // Write channel
  // ************************************************
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire b_done = bvalid_reg && s_axi_bready;
  wire aw_full_next = (aw_full_reg || aw_take) && !do_write;
  wire w_full_next = (w_full_reg || w_take) && !do_write;
  wire bvalid_next = (bvalid_reg && !b_done) || do_write;
  wire wr_low = aw_addr_reg == OFF_MATCH_LOW;
  wire wr_mlow = aw_addr_reg == OFF_MASK_LOW;
  wire wr_high = aw_addr_reg == OFF_MATCH_HIGH;
  wire wr_mhigh = aw_addr_reg == OFF_MASK_HIGH;
  wire wr_count = aw_addr_reg == OFF_HIT_COUNT;
  wire wr_hit = wr_low || wr_mlow || wr_high || wr_mhigh || wr_count;
  wire [DATA_W-1:0] wr_old = wr_low ? match_low_reg :
                             wr_mlow ? packet_filter_mask_low_reg :
                             wr_high ? match_high_reg : mask_high_reg;
  wire [DATA_W-1:0] wr_merged;

  // In the match and mask registers, byte lanes not strobed keep their old contents
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign wr_merged[lane*8 +: 8] = w_strb_reg[lane] ? w_data_reg[lane*8 +: 8]
                                                        : wr_old[lane*8 +: 8];
    end
  endgenerate

  // Reserved bits are dropped on write so they cannot disturb the compare
  wire [DATA_W-1:0] wr_low_val = wr_merged & LOW_FIELDS;
  wire [DATA_W-1:0] wr_high_val = wr_merged & HIGH_FIELDS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= !aw_full_next && !bvalid_next;
      wready_reg <= !w_full_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_low_reg <= RESET_VAL;
      packet_filter_mask_low_reg <= RESET_VAL;
      match_high_reg <= RESET_VAL;
      mask_high_reg <= RESET_VAL;
    end else if (do_write) begin
      if (wr_low) match_low_reg <= wr_low_val;
      if (wr_mlow) packet_filter_mask_low_reg <= wr_low_val;
      if (wr_high) match_high_reg <= wr_high_val;
      if (wr_mhigh) mask_high_reg <= wr_high_val;
    end
  end

  // ************************************************
  // Read channel
  // ************************************************
  logic arready_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire ar_take = s_axi_arvalid && arready_reg;
  wire r_done = rvalid_reg && s_axi_rready;
  wire [ADDR_W-1:0] rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'h0};
  wire rd_hit = rd_addr == OFF_MATCH_LOW || rd_addr == OFF_MASK_LOW ||
                rd_addr == OFF_MATCH_HIGH || rd_addr == OFF_MASK_HIGH ||
                rd_addr == OFF_HIT_COUNT;
  wire [DATA_W-1:0] rd_val = rd_addr == OFF_MATCH_LOW ? match_low_reg :
                             rd_addr == OFF_MASK_LOW ? packet_filter_mask_low_reg :
                             rd_addr == OFF_MATCH_HIGH ? match_high_reg :
                             rd_addr == OFF_MASK_HIGH ? mask_high_reg :
                             rd_addr == OFF_HIT_COUNT ? hit_count_reg : RESET_VAL;
  wire rvalid_next = (rvalid_reg && !r_done) || ar_take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= RESET_VAL;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_val;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ************************************************
  // Packet compare
  // ************************************************
  // Header laid out exactly like the match and mask registers
  wire [DATA_W-1:0] hdr_low = (DATA_W'(pkt_hdr.remote_node[4]) << RN_TOP_BIT)
                            | (DATA_W'(pkt_hdr.dest_node_field) << DEST_LSB)
                            | (DATA_W'(pkt_hdr.msg_class_field) << CLASS_LSB)
                            | (DATA_W'(pkt_hdr.opcode_field) << OPC_LSB)
                            | (DATA_W'(pkt_hdr.virt_net_field) << VNET_LSB);
  wire [DATA_W-1:0] hdr_high = (DATA_W'(pkt_hdr.resp_line_state) << STATE_LSB)
                             | (DATA_W'(pkt_hdr.remote_node[3:0]) << RN_LOW_LSB);
  // Only masked bits must match; all-zero low and high masks hit every packet
  wire low_ok = ((hdr_low ^ match_low_reg) & packet_filter_mask_low_reg) == '0;
  wire high_ok = ((hdr_high ^ match_high_reg) & mask_high_reg) == '0;
  wire hit_now = pkt_valid && low_ok && high_ok;

  // The hit count wraps; software reads it as a running total
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_reg <= 1'b0;
      hit_count_reg <= RESET_VAL;
    end else begin
      hit_reg <= hit_now;
      if (do_write && wr_count) begin
        hit_count_reg <= RESET_VAL;
      end else if (hit_reg) begin
        hit_count_reg <= hit_count_reg + DATA_W'(1);
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign filter_hit_event = hit_reg;

  // ************************************************
  // Checks
  // ************************************************
  wire low_clean = packet_filter_mask_low_reg[31:13] == '0 && mask_high_reg == '0;
  wire [3:0] p_mc = pkt_hdr.msg_class_field;
  wire [3:0] p_op = pkt_hdr.opcode_field;

  property p_low_preset(logic [12:0] mt, logic [12:0] mk, logic cond);
    @(posedge aclk) disable iff (!aresetn)
    (pkt_valid && low_clean && match_low_reg[12:0] == mt &&
     packet_filter_mask_low_reg[12:0] == mk) |=> (filter_hit_event == $past(cond));
  endproperty

  a_reserved_mask_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (packet_filter_mask_low_reg & ~LOW_FIELDS) == '0)
    else $error("reserved mask bits set");
  a_opc_mask_field: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_mlow && w_strb_reg[1:0] == 2'h3) |=>
    packet_filter_mask_low_reg[8:5] == $past(w_data_reg[8:5]))
    else $error("opcode mask not stored");
  a_drs_any: assert property (p_low_preset(PM_DRS, PK_CLASS,
    p_mc == data_response_class))
    else $error("data response preset wrong");
  a_drs_line: assert property (p_low_preset(PM_DRS, PK_TWO,
    p_mc == data_response_class && p_op[3:2] == 2'h0))
    else $error("line response preset wrong");
  a_wb_shared: assert property (p_low_preset(PM_WB_S, PK_OPC,
    p_mc == data_response_class && p_op == 4'h5))
    else $error("writeback shared preset wrong");
  a_drs_partial: assert property (p_low_preset(PM_DRS_PART, PK_SIZE,
    p_mc == data_response_class && p_op[3]))
    else $error("partial data preset wrong");
  a_ncb_any: assert property (p_low_preset(PM_NCB, PK_CLASS,
    p_mc == noncoherent_bypass_class))
    else $error("bypass preset wrong");
  a_ncb_nine: assert property (p_low_preset(PM_NCB, PK_SIZE,
    p_mc == noncoherent_bypass_class && !p_op[3]))
    else $error("nine flit preset wrong");
  a_ncb_eleven: assert property (p_low_preset(PM_NCB_11, PK_SIZE,
    p_mc == noncoherent_bypass_class && p_op[3]))
    else $error("eleven flit preset wrong");
  a_ncb_intr: assert property (p_low_preset(PM_NCB_11, PK_TWO,
    p_mc == noncoherent_bypass_class && p_op[3:2] == 2'h2))
    else $error("interrupt preset wrong");
  a_state_mod: assert property (@(posedge aclk) disable iff (!aresetn)
    (pkt_valid && match_low_reg == 32'(PM_DRS) && packet_filter_mask_low_reg == 32'(PK_OPC)
     && mask_high_reg == (32'(PK_STATE) << STATE_LSB)
     && match_high_reg == (32'(STATE_MOD) << STATE_LSB))
    |=> filter_hit_event == $past(p_mc == data_response_class && p_op == 4'h0
        && pkt_hdr.resp_line_state == STATE_MOD))
    else $error("state preset wrong");
  a_cmp_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    (pkt_valid && match_low_reg == 32'(PM_DRS_CMP) && packet_filter_mask_low_reg == 32'(PK_OPC)
     && mask_high_reg == (32'(PK_STATE) << STATE_LSB)
     && match_high_reg == (32'(STATE_EXCL) << STATE_LSB))
    |=> filter_hit_event == $past(p_mc == data_response_class && p_op == 4'h2
        && pkt_hdr.resp_line_state == STATE_EXCL))
    else $error("completion preset wrong");
  a_frc_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
    (pkt_valid && match_low_reg == 32'(PM_DRS_FRC) && packet_filter_mask_low_reg == 32'(PK_OPC)
     && mask_high_reg == (32'(PK_STATE) << STATE_LSB)
     && match_high_reg == (32'(STATE_FWD) << STATE_LSB)
     && p_mc == data_response_class && p_op == 4'h1 && pkt_hdr.resp_line_state == STATE_FWD)
    |=> filter_hit_event)
    else $error("force ack preset missed");
  a_no_packet_no_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    !pkt_valid |=> !filter_hit_event)
    else $error("hit without packet");
  a_hit_counted: assert property (@(posedge aclk) disable iff (!aresetn)
    (filter_hit_event && !(do_write && wr_count)) |=>
    hit_count_reg == $past(hit_count_reg) + 32'h1)
    else $error("hit not counted");

  c_any_hit: cover property (@(posedge aclk) disable iff (!aresetn) filter_hit_event);
  c_write_done: cover property (@(posedge aclk) disable iff (!aresetn) b_done);
  c_read_done: cover property (@(posedge aclk) disable iff (!aresetn) r_done);
  c_state_hit: cover property (@(posedge aclk) disable iff (!aresetn)
    hit_now && mask_high_reg != '0);
endmodule : lpf_filter
`default_nettype wire

// File: logic/lpf_pkg.sv
`default_nettype none
package lpf_pkg;
  // ************************************************
  // Register map and bus
  // ************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_MATCH_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MATCH_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK_HIGH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_HIT_COUNT = 8'h10;
  localparam logic [DATA_W-1:0] RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Writable field bits; reserved ranges always read zero
  localparam logic [DATA_W-1:0] LOW_FIELDS = 32'h8003_fff8;
  localparam logic [DATA_W-1:0] HIGH_FIELDS = 32'h000f_000f;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int RN_TOP_BIT = 31;
  localparam int DEST_LSB = 13;
  localparam int CLASS_LSB = 9;
  localparam int OPC_LSB = 5;
  localparam int VNET_LSB = 3;
  localparam int STATE_LSB = 16;
  localparam int RN_LOW_LSB = 0;

  // ************************************************
  // Message classes and line states
  // ************************************************
  localparam logic [3:0] data_response_class = 4'he;
  localparam logic [3:0] noncoherent_bypass_class = 4'hc;
  localparam logic [3:0] STATE_MOD = 4'h8;
  localparam logic [3:0] STATE_EXCL = 4'h4;
  localparam logic [3:0] STATE_SHARED = 4'h2;
  localparam logic [3:0] STATE_FWD = 4'h1;
  localparam logic [3:0] STATE_INVALID = 4'h0;

  // Preset pairs for the low 13 bits, and the line state mask PK_STATE
  localparam logic [12:0] PM_DRS = 13'h1c00;
  localparam logic [12:0] PM_DRS_CMP = 13'h1c40;
  localparam logic [12:0] PM_DRS_FRC = 13'h1c20;
  localparam logic [12:0] PM_WB_I = 13'h1c80;
  localparam logic [12:0] PM_WB_S = 13'h1ca0;
  localparam logic [12:0] PM_WB_E = 13'h1cc0;
  localparam logic [12:0] PM_DRS_PART = 13'h1d00;
  localparam logic [12:0] PM_NCB = 13'h1800;
  localparam logic [12:0] PM_NCB_11 = 13'h1900;
  localparam logic [12:0] PK_CLASS = 13'h1e00;
  localparam logic [12:0] PK_SIZE = 13'h1f00;
  localparam logic [12:0] PK_TWO = 13'h1f80;
  localparam logic [12:0] PK_OPC = 13'h1fe0;
  localparam logic [3:0] PK_STATE = 4'hf;

  typedef struct packed {
    logic [4:0] remote_node;
    logic [4:0] dest_node_field;
    logic [3:0] msg_class_field;
    logic [3:0] opcode_field;
    logic [1:0] virt_net_field;
    logic [3:0] resp_line_state;
  } lpf_hdr_t;
endpackage : lpf_pkg
`default_nettype wire

// File: dv/lpf_pkt_src.sv
`timescale 1ns/100ps
`default_nettype none
module lpf_pkt_src (
  input wire logic aclk,
  output logic pkt_valid,
  output var lpf_pkg::lpf_hdr_t pkt_hdr
);
  import lpf_pkg::*;
  // ****************
  // Serviced packet traffic
  // ****************
  initial begin
    pkt_valid = 1'h0;
    pkt_hdr = '0;
  end
  // Sends may be chained, giving back-to-back packets
  task automatic send(input lpf_hdr_t h);
    @(posedge aclk);
    pkt_valid <= 1'h1;
    pkt_hdr <= h;
  endtask : send
  // Stale header is inverted so it never passes for a live one
  task automatic idle();
    @(posedge aclk);
    pkt_valid <= 1'h0;
    pkt_hdr <= ~pkt_hdr;
  endtask : idle
endmodule : lpf_pkt_src
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb_top;
  import lpf_pkg::*;
  // ****************
  // Clock, bus and packet signals
  // ****************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, nh;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, hit, pv;
  logic [1:0] bresp, rresp;
  lpf_hdr_t hdr;
  int fail_count = 0;
  int total_checks = 0;
  localparam logic [3:0] D = data_response_class;
  localparam logic [3:0] N = noncoherent_bypass_class;
  localparam logic [7:0] offs[5] = '{OFF_MATCH_LOW, OFF_MASK_LOW, OFF_MATCH_HIGH,
    OFF_MASK_HIGH, OFF_HIT_COUNT};
  always #25 aclk = ~aclk;
  lpf_filter uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pkt_valid(pv),
    .pkt_hdr(hdr), .filter_hit_event(hit));
  lpf_pkt_src src (.aclk(aclk), .pkt_valid(pv), .pkt_hdr(hdr));
  // ****************
  // Preset table: low match, low mask, state match, state mask, class, opcode, state, hit
  // ****************
  typedef struct packed {
    logic [12:0] lm, lk;
    logic [3:0] hm, hk, c, o, s;
    logic e;
  } lpf_row_t;
  lpf_row_t r;
  localparam lpf_row_t rows[26] = '{
    '{PM_DRS, PK_CLASS, 4'h0, 4'h0, D, 4'h8, 4'h0, 1'h1},
    '{PM_DRS, PK_CLASS, 4'h0, 4'h0, N, 4'h8, 4'h0, 1'h0},
    '{PM_DRS, PK_TWO, 4'h0, 4'h0, D, 4'h3, 4'h0, 1'h1},
    '{PM_DRS, PK_TWO, 4'h0, 4'h0, D, 4'h4, 4'h0, 1'h0},
    '{PM_DRS, PK_OPC, 4'h8, 4'hf, D, 4'h0, 4'h8, 1'h1},
    '{PM_DRS, PK_OPC, 4'h8, 4'hf, D, 4'h0, 4'h4, 1'h0},
    '{PM_DRS, PK_OPC, 4'h4, 4'hf, D, 4'h0, 4'h4, 1'h1},
    '{PM_DRS, PK_OPC, 4'h1, 4'hf, D, 4'h0, 4'h1, 1'h1},
    '{PM_DRS_CMP, PK_OPC, 4'h4, 4'hf, D, 4'h2, 4'h4, 1'h1},
    '{PM_DRS_CMP, PK_OPC, 4'h1, 4'hf, D, 4'h0, 4'h1, 1'h0},
    '{PM_DRS_FRC, PK_OPC, 4'h1, 4'hf, D, 4'h1, 4'h1, 1'h1},
    '{PM_DRS_FRC, PK_OPC, 4'h4, 4'hf, D, 4'h1, 4'h2, 1'h0},
    '{PM_WB_I, PK_OPC, 4'h0, 4'h0, D, 4'h4, 4'h0, 1'h1},
    '{PM_WB_S, PK_OPC, 4'h0, 4'h0, D, 4'h5, 4'h0, 1'h1},
    '{PM_WB_E, PK_OPC, 4'h0, 4'h0, D, 4'h6, 4'h0, 1'h1},
    '{PM_WB_E, PK_OPC, 4'h0, 4'h0, D, 4'h5, 4'h0, 1'h0},
    '{PM_DRS, PK_SIZE, 4'h0, 4'h0, D, 4'h7, 4'h0, 1'h1},
    '{PM_DRS, PK_SIZE, 4'h0, 4'h0, D, 4'h8, 4'h0, 1'h0},
    '{PM_DRS_PART, PK_SIZE, 4'h0, 4'h0, D, 4'h8, 4'h0, 1'h1},
    '{PM_NCB, PK_CLASS, 4'h0, 4'h0, N, 4'hf, 4'h0, 1'h1},
    '{PM_NCB, PK_CLASS, 4'h0, 4'h0, 4'hd, 4'h0, 4'h0, 1'h0},
    '{PM_NCB, PK_SIZE, 4'h0, 4'h0, N, 4'h7, 4'h0, 1'h1},
    '{PM_NCB, PK_SIZE, 4'h0, 4'h0, N, 4'h8, 4'h0, 1'h0},
    '{PM_NCB_11, PK_SIZE, 4'h0, 4'h0, N, 4'hb, 4'h0, 1'h1},
    '{PM_NCB_11, PK_TWO, 4'h0, 4'h0, N, 4'h9, 4'h0, 1'h1},
    '{PM_NCB_11, PK_TWO, 4'h0, 4'h0, N, 4'hc, 4'h0, 1'h0}};
  localparam logic [31:0] fm[3] = '{32'h8000_0000, 32'h0002_a000, 32'h0000_0010};
  localparam logic [31:0] fk[3] = '{32'h8000_0000, 32'h0003_e000, 32'h0000_0018};
  localparam lpf_hdr_t fh[6] = '{'{5'h10, 5'h0, 4'h0, 4'h0, 2'h0, 4'h0},
    '{5'h0f, 5'h0, 4'h0, 4'h0, 2'h0, 4'h0}, '{5'h0, 5'h15, 4'h0, 4'h0, 2'h0, 4'h0},
    '{5'h0, 5'h14, 4'h0, 4'h0, 2'h0, 4'h0}, '{5'h0, 5'h0, 4'h0, 4'h0, 2'h2, 4'h0},
    '{5'h0, 5'h0, 4'h0, 4'h0, 2'h3, 4'h0}};
  // ****************
  // Tasks
  // ****************
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // Single bus transfer; w high writes, low reads and compares d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
    end else begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
    end
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
    end while (!(w ? bvalid : rvalid) && n < 50);
    bready <= 1'h0;
    rready <= 1'h0;
    if (!(w ? bvalid : rvalid)) begin
      `CHK("bus answer", 1'h1, 1'h0)
      close_out();
    end else begin
      `CHK("resp", er, (w ? bresp : rresp))
      if (!w) `CHK("rdata", d, rdata)
    end
  endtask : bus
  task automatic pkt(input lpf_hdr_t h, input logic e);
    src.send(h);
    src.idle();
    #1 `CHK("hit", e, hit)
    @(posedge aclk);
    #1 `CHK("hit idle", 1'h0, hit)
  endtask : pkt
  task automatic rst_chk();
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 5; i++) bus(1'h0, offs[i], 32'h0, RESP_OKAY);
  endtask : rst_chk
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  // ****************
  // Main sequence; reserved mask bits are written as zero except in the wstrb 4'h2 write of 32'hffff_ffff
  // ****************
  initial begin
    nh = 32'h0;
    rst_chk();
    done("reset");
    bus(1'h1, OFF_MASK_LOW, 32'h8002_a5e8, RESP_OKAY);
    bus(1'h0, OFF_MASK_LOW, 32'h8002_a5e8, RESP_OKAY);
    wstrb <= 4'h2;
    bus(1'h1, OFF_MASK_LOW, 32'hffff_ffff, RESP_OKAY);
    wstrb <= 4'hf;
    bus(1'h0, OFF_MASK_LOW, 32'h8002_ffe8, RESP_OKAY);
    bus(1'h1, OFF_MASK_HIGH, 32'h000f_0005, RESP_OKAY);
    bus(1'h0, OFF_MASK_HIGH, 32'h000f_0005, RESP_OKAY);
    bus(1'h1, 8'h20, 32'h1234_5678, RESP_SLVERR);
    bus(1'h0, 8'h20, 32'h0, RESP_SLVERR);
    done("registers");
    for (int i = 0; i < 26; i++) begin
      r = rows[i];
      bus(1'h1, OFF_MATCH_LOW, {19'h0, r.lm}, RESP_OKAY);
      bus(1'h1, OFF_MASK_LOW, {19'h0, r.lk}, RESP_OKAY);
      bus(1'h1, OFF_MATCH_HIGH, {12'h0, r.hm, 16'h0}, RESP_OKAY);
      bus(1'h1, OFF_MASK_HIGH, {12'h0, r.hk, 16'h0}, RESP_OKAY);
      pkt('{5'h13, 5'h0a, r.c, r.o, 2'h1, r.s}, r.e);
      nh = nh + {31'h0, r.e};
    end
    bus(1'h0, OFF_HIT_COUNT, nh, RESP_OKAY);
    bus(1'h1, OFF_HIT_COUNT, 32'h0, RESP_OKAY);
    bus(1'h0, OFF_HIT_COUNT, 32'h0, RESP_OKAY);
    done("presets");
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, OFF_MATCH_LOW, fm[i], RESP_OKAY);
      bus(1'h1, OFF_MASK_LOW, fk[i], RESP_OKAY);
      pkt(fh[2*i], 1'h1);
      pkt(fh[2*i+1], 1'h0);
    end
    done("fields");
    bus(1'h1, OFF_MATCH_LOW, {19'h0, PM_DRS}, RESP_OKAY);
    bus(1'h1, OFF_MASK_LOW, {19'h0, PK_CLASS}, RESP_OKAY);
    src.send('{5'h0, 5'h0, D, 4'h0, 2'h0, 4'h0});
    src.send('{5'h0, 5'h0, N, 4'h0, 2'h0, 4'h0});
    #1 `CHK("hit b2b", 1'h1, hit)
    src.send('{5'h0, 5'h0, D, 4'h3, 2'h0, 4'h0});
    #1 `CHK("hit b2b", 1'h0, hit)
    src.idle();
    #1 `CHK("hit b2b", 1'h1, hit)
    @(posedge aclk);
    #1 `CHK("hit b2b", 1'h0, hit)
    done("back to back");
    rst_chk();
    done("second reset");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
